/* File: design/rpc_pkg.sv */
// Constants, types and helpers for the root pointer and context invalidation registers
// Overview of operation
// RULE1 - Root base writes are only staged; the set-root-pointer command makes them active.
// RULE2 - Root base sits in bits 63:12; table is one aligned page, low bits zero.
// RULE3 - Root base bits at and above the host address width are not stored.
// RULE4 - Mode 00 legacy, 01 scalable, 10 reserved, 11 aborts all DMA.
// RULE5 - Without enhanced pointer set, software keeps mode fixed while translation runs.
// RULE6 - Writing the top byte with invalidate bit set starts a context invalidation.
// RULE7 - Software gives the requested granularity in the same write that sets the bit.
// RULE8 - Software must not write the command while the invalidate bit reads one.
// RULE9 - On finishing, hardware clears the invalidate bit and reports the actual granularity.
// RULE10 - Any non-legacy mode makes a request incorrect: ignored, error code 00 reported.
// RULE11 - Requested granularity: 00 reserved, 01 global, 10 domain, 11 device.
// RULE12 - Actual may be coarser; device-selective only reported for device-selective requests.
// RULE13 - Set-root-pointer clears pointer status; status sets once the load has finished.
package rpc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Byte offsets on the register port
  localparam logic [ADDR_W-1:0] OFF_GCMD = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_GSTS = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_RTA_LO = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_RTA_HI = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_CCMD_LO = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_CCMD_HI = 12'h02C;
  localparam logic [ADDR_W-1:0] OFF_INT_STS = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 12'h034;

  // Field positions
  localparam int GCMD_SET_ROOT_POINTER_CMD_BIT = 30;
  localparam int GSTS_ROOT_POINTER_STATUS_BIT = 30;
  localparam int RTA_BASE_LSB = 12;
  localparam int RTA_TTM_LSB = 10;
  localparam int CCMD_ICC_BIT = 63;
  localparam int CCMD_REQUESTED_INVAL_GRANULARITY_LSB = 61;
  localparam int CCMD_ACTUAL_INVAL_GRANULARITY_LSB = 59;
  localparam int CCMD_FM_LSB = 32;
  localparam int CCMD_SID_LSB = 16;
  localparam int CCMD_DID_LSB = 0;
  localparam int TOP_BYTE_EN = 3;
  localparam logic [63:0] TTM_MASK = 64'h0000_0000_0000_0C00;
  localparam logic [63:0] CCMD_SW_MASK = 64'h6000_0003_FFFF_FFFF;
  localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] ZERO32 = 32'h0000_0000;

  // Interrupt status bits
  localparam int INT_W = 3;
  localparam int INT_INVAL_DONE = 0;
  localparam int INT_INVAL_ERR = 1;
  localparam int INT_ROOT_LOADED = 2;

  // Root pointer load time
  localparam int CLK_FREQ_MHZ = 200;
  localparam int ROOT_LOAD_NS = 20;
  localparam int ROOT_LOAD_CALC = (ROOT_LOAD_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int ROOT_LOAD_CYC = (ROOT_LOAD_CALC < 1) ? 1 : ROOT_LOAD_CALC;

  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_SCALABLE = 2'b01,
    MODE_RESERVED = 2'b10,
    MODE_ABORT = 2'b11
  } rpc_mode_type;

  typedef enum logic [1:0] {
    GRAN_ERROR = 2'b00,
    GRAN_GLOBAL = 2'b01,
    GRAN_DOMAIN = 2'b10,
    GRAN_DEVICE = 2'b11
  } rpc_gran_type;

  // Byte-lane merge of a 32-bit write into an old value
  function automatic logic [DATA_W-1:0] rpc_merge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wdata,
                                                  input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

/* File: design/rpc_inval_if.sv */
// Request and completion signals between the register file and the invalidation engine
`timescale 1ns/10ps
interface rpc_inval_if;
  import rpc_pkg::*;
  logic start;
  logic legal;
  rpc_gran_type reqGran;
  logic [15:0] domainIdentifier;
  logic [15:0] sourceIdentifier;
  logic [1:0] functionMask;
  logic busy;
  logic done;
  rpc_gran_type actGran;
  modport engine (input start, legal, reqGran, domainIdentifier, sourceIdentifier,
                  functionMask, output busy, done, actGran);
  modport ctrl (output start, legal, reqGran, domainIdentifier, sourceIdentifier,
                functionMask, input busy, done, actGran);
endinterface

/* File: design/rpc_root_load.sv */
// Applies the staged root table base and mode on a set-root-pointer command
`timescale 1ns/10ps
module rpc_root_load
  import rpc_pkg::*;
#(
  parameter int LOAD_CYC = ROOT_LOAD_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command and staged value
  input wire logic start,
  input wire logic [63:0] stagedValue,
  // Active state
  output logic [63:0] activeRootBase,
  output rpc_mode_type activeMode,
  output logic dmaAbort,
  output logic rootPointerStatus,
  output logic loaded
);
  logic [7:0] cnt;
  wire lastCycle = (cnt == 8'(1));
  wire rpc_mode_type stagedMode = rpc_mode_type'(stagedValue[RTA_TTM_LSB +: 2]);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      rootPointerStatus <= 1'b0;
      loaded <= 1'b0;
      activeRootBase <= ZERO64;
      activeMode <= MODE_LEGACY;
      dmaAbort <= 1'b0;
    end else begin
      loaded <= 1'b0;
      if (start) begin
        cnt <= 8'(LOAD_CYC);
        rootPointerStatus <= 1'b0; // RULE13
      end else if (cnt != '0) begin
        cnt <= cnt - 8'(1);
        if (lastCycle) begin
          // Staged value becomes live only here
          activeRootBase <= {stagedValue[63:RTA_BASE_LSB], 12'h000}; // RULE1 RULE2
          activeMode <= stagedMode;
          dmaAbort <= (stagedMode == MODE_ABORT); // RULE4
          rootPointerStatus <= 1'b1; // RULE13
          loaded <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_root_pointer_status_clear;
    start |=> !rootPointerStatus;
  endproperty
  a_root_pointer_status_clear: assert property (p_root_pointer_status_clear) else $error("pointer status not cleared"); // RULE13

  // Last count cycle with no restart: the load lands at the following edge
  sequence s_load_last;
    lastCycle && !start;
  endsequence

  property p_root_pointer_status_set;
    s_load_last |=> rootPointerStatus && $rose(loaded);
  endproperty
  a_root_pointer_status_set: assert property (p_root_pointer_status_set) else $error("pointer status not set after load"); // RULE13

  property p_abort_mode;
    dmaAbort == (activeMode == MODE_ABORT);
  endproperty
  a_abort_mode: assert property (p_abort_mode) else $error("abort flag disagrees with mode"); // RULE4
endmodule

/* File: design/rpc_ctx_inval.sv */
// Context-cache invalidation engine with handshake toward the cache
`timescale 1ns/10ps
module rpc_ctx_inval
  import rpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register side
  rpc_inval_if.engine inv,
  // Cache side
  output logic ccReq,
  output rpc_gran_type ccGran,
  output logic [15:0] ccDomain,
  output logic [15:0] ccSource,
  output logic [1:0] ccFuncMask,
  input wire logic ccDone,
  input wire rpc_gran_type ccActualGran
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_FINISH = 2'b10
  } rpc_inval_state_type;

  rpc_inval_state_type state;
  rpc_gran_type actGran;
  // Device reports on a non-device ask are folded to global so software never sees device on a coarser ask
  wire rpc_gran_type clampedGran =
      (ccActualGran == GRAN_DEVICE && ccGran != GRAN_DEVICE) ? GRAN_GLOBAL : ccActualGran;

  assign inv.busy = (state != ST_IDLE);
  assign inv.done = (state == ST_FINISH);
  assign inv.actGran = actGran;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      actGran <= GRAN_ERROR;
      ccReq <= 1'b0;
      ccGran <= GRAN_ERROR;
      ccDomain <= '0;
      ccSource <= '0;
      ccFuncMask <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (inv.start && inv.legal) begin
            ccReq <= 1'b1;
            ccGran <= inv.reqGran;
            ccDomain <= inv.domainIdentifier;
            ccSource <= inv.sourceIdentifier;
            ccFuncMask <= inv.functionMask;
            state <= ST_WAIT;
          end else if (inv.start) begin
            actGran <= GRAN_ERROR; // RULE10
            state <= ST_FINISH;
          end
        end
        ST_WAIT: begin
          if (ccDone) begin
            ccReq <= 1'b0;
            actGran <= clampedGran; // RULE12
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_err_finish;
    inv.done && !ccReq && actGran == GRAN_ERROR;
  endsequence

  property p_illegal_ignored;
    inv.start && !inv.legal && !inv.busy |=> s_err_finish;
  endproperty
  a_illegal_ignored: assert property (p_illegal_ignored) else $error("bad request not ignored"); // RULE10

  property p_device_only;
    inv.done && ccGran != GRAN_DEVICE |-> actGran != GRAN_DEVICE;
  endproperty
  a_device_only: assert property (p_device_only) else $error("device report on other ask"); // RULE12

  property p_req_held;
    ccReq && !ccDone |=> ccReq;
  endproperty
  a_req_held: assert property (p_req_held) else $error("cache request dropped early"); // RULE6
endmodule

/* File: design/rpc_regs_top.sv */
// Register file for the root table base and context command, with interrupt status
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module rpc_regs_top
  import rpc_pkg::*;
#(
  parameter int HOST_ADDR_WIDTH = 48,
  parameter int LOAD_CYC = ROOT_LOAD_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic [BE_W-1:0] regWrByteEn,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  // Interrupt
  output logic irq,
  // Active translation setup
  output logic [63:0] activeRootBase,
  output rpc_mode_type activeMode,
  output logic dmaAbort,
  // Context cache handshake
  output logic ccReq,
  output rpc_gran_type ccGran,
  output logic [15:0] ccDomain,
  output logic [15:0] ccSource,
  output logic [1:0] ccFuncMask,
  input wire logic ccDone,
  input wire rpc_gran_type ccActualGran
);
  // Bits below the host address width and above the page offset, plus the mode field
  localparam logic [63:0] BASE_MASK =
      (HOST_ADDR_WIDTH >= 64) ? ~64'h0000_0000_0000_0FFF :
      (((64'h0000_0000_0000_0001 << HOST_ADDR_WIDTH) - 64'h0000_0000_0000_0001)
       & ~64'h0000_0000_0000_0FFF);
  localparam logic [63:0] RTA_MASK = BASE_MASK | TTM_MASK;

  rpc_inval_if inv ();

  logic [63:0] rtaReg;
  logic [63:0] ccmdReg;
  logic iccBit;
  rpc_gran_type actual_inval_granularity;
  logic [INT_W-1:0] intSts;
  logic [INT_W-1:0] intMask;
  logic rootPointerStatus;
  logic rootLoaded;
  logic [DATA_W-1:0] next_regRdData;
  logic [INT_W-1:0] next_intSts;

  // Address decode
  wire wrGcmd = regWr && (regAddr == OFF_GCMD);
  wire wrRtaLo = regWr && (regAddr == OFF_RTA_LO);
  wire wrRtaHi = regWr && (regAddr == OFF_RTA_HI);
  wire wrCcmdLo = regWr && (regAddr == OFF_CCMD_LO);
  wire wrCcmdHi = regWr && (regAddr == OFF_CCMD_HI);
  wire wrIntSts = regWr && (regAddr == OFF_INT_STS);
  wire wrIntMask = regWr && (regAddr == OFF_INT_MASK);

  // Set-root-pointer command is a self-clearing bit of the global command word
  wire setRootPointer = wrGcmd && regWrByteEn[TOP_BYTE_EN] && regWrData[GCMD_SET_ROOT_POINTER_CMD_BIT];

  // Staged root table base after the current write
  wire [DATA_W-1:0] rtaLoMerged = rpc_merge(rtaReg[31:0], regWrData, regWrByteEn);
  wire [DATA_W-1:0] rtaHiMerged = rpc_merge(rtaReg[63:32], regWrData, regWrByteEn);
  wire [63:0] next_rtaReg = wrRtaLo ? ({rtaReg[63:32], rtaLoMerged} & RTA_MASK) :
                            wrRtaHi ? ({rtaHiMerged, rtaReg[31:0]} & RTA_MASK) : rtaReg;

  // Context command writes are dropped while an invalidation is pending
  wire ccmdWrOk = !iccBit;
  wire [DATA_W-1:0] ccmdLoMerged = rpc_merge(ccmdReg[31:0], regWrData, regWrByteEn);
  wire [DATA_W-1:0] ccmdHiMerged = rpc_merge(ccmdReg[63:32], regWrData, regWrByteEn);
  wire [63:0] ccmdWrValue = wrCcmdLo ? {ccmdReg[63:32], ccmdLoMerged} :
                            {ccmdHiMerged, ccmdReg[31:0]};
  wire [63:0] next_ccmdReg = ((wrCcmdLo || wrCcmdHi) && ccmdWrOk) ?
                             (ccmdWrValue & CCMD_SW_MASK) : ccmdReg;

  // Only a write reaching the top byte with the invalidate bit set starts work
  wire iccRequest = wrCcmdHi && ccmdWrOk && regWrByteEn[TOP_BYTE_EN]
                    && ccmdWrValue[CCMD_ICC_BIT]; // RULE6
  wire rpc_gran_type reqGran = rpc_gran_type'(ccmdWrValue[CCMD_REQUESTED_INVAL_GRANULARITY_LSB +: 2]); // RULE7 RULE11
  wire rpc_mode_type stagedMode = rpc_mode_type'(rtaReg[RTA_TTM_LSB +: 2]);
  // Reserved granularity is also treated as an incorrect request
  wire requestLegal = (stagedMode == MODE_LEGACY) && (reqGran != GRAN_ERROR); // RULE10

  assign inv.start = iccRequest; // RULE6
  assign inv.legal = requestLegal;
  assign inv.reqGran = reqGran;
  assign inv.domainIdentifier = ccmdWrValue[CCMD_DID_LSB +: 16];
  assign inv.sourceIdentifier = ccmdWrValue[CCMD_SID_LSB +: 16];
  assign inv.functionMask = ccmdWrValue[CCMD_FM_LSB +: 2];

  // Interrupt events
  wire [INT_W-1:0] intEvents = {rootLoaded,
                                inv.done && (inv.actGran == GRAN_ERROR),
                                inv.done && (inv.actGran != GRAN_ERROR)};
  wire [INT_W-1:0] intClear = wrIntSts ? regWrData[INT_W-1:0] : '0;
  wire [DATA_W-1:0] intMaskWord = rpc_merge({{(DATA_W-INT_W){1'b0}}, intMask},
                                            regWrData, regWrByteEn);
  // Only the implemented mask bits are kept
  wire [INT_W-1:0] intMaskMerged = intMaskWord[INT_W-1:0];

  // Event set wins over a write-one clear in the same cycle
  always_comb begin
    next_intSts = (intSts & ~intClear) | intEvents;
  end

  // Readback assembly
  wire [63:0] ccmdView = ccmdReg
                       | ({63'h0, iccBit} << CCMD_ICC_BIT)
                       | ({62'h0, actual_inval_granularity} << CCMD_ACTUAL_INVAL_GRANULARITY_LSB);

  always_comb begin
    if (regAddr == OFF_GSTS) begin
      next_regRdData = {{(DATA_W-1){1'b0}}, rootPointerStatus} << GSTS_ROOT_POINTER_STATUS_BIT;
    end else if (regAddr == OFF_RTA_LO) begin
      next_regRdData = rtaReg[31:0];
    end else if (regAddr == OFF_RTA_HI) begin
      next_regRdData = rtaReg[63:32];
    end else if (regAddr == OFF_CCMD_LO) begin
      next_regRdData = ccmdView[31:0];
    end else if (regAddr == OFF_CCMD_HI) begin
      next_regRdData = ccmdView[63:32];
    end else if (regAddr == OFF_INT_STS) begin
      next_regRdData = {{(DATA_W-INT_W){1'b0}}, intSts};
    end else if (regAddr == OFF_INT_MASK) begin
      next_regRdData = {{(DATA_W-INT_W){1'b0}}, intMask};
    end else begin
      // Command word and unmapped addresses read as zero
      next_regRdData = ZERO32;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= ZERO32;
    end else begin
      regRdData <= regRd ? next_regRdData : ZERO32;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rtaReg <= ZERO64;
      ccmdReg <= ZERO64;
    end else begin
      rtaReg <= next_rtaReg; // RULE1 RULE3
      ccmdReg <= next_ccmdReg;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      iccBit <= 1'b0;
      actual_inval_granularity <= GRAN_ERROR;
    end else if (iccRequest) begin
      iccBit <= 1'b1; // RULE6
    end else if (inv.done) begin
      iccBit <= 1'b0; // RULE9
      actual_inval_granularity <= inv.actGran; // RULE9 RULE12
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      intSts <= '0;
      intMask <= '0;
      irq <= 1'b0;
    end else begin
      intSts <= next_intSts;
      if (wrIntMask) begin
        intMask <= intMaskMerged;
      end
      irq <= |(next_intSts & intMask);
    end
  end

  rpc_root_load #(
    .LOAD_CYC(LOAD_CYC)
  ) u_root_load (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(setRootPointer),
    .stagedValue(rtaReg),
    .activeRootBase(activeRootBase),
    .activeMode(activeMode),
    .dmaAbort(dmaAbort),
    .rootPointerStatus(rootPointerStatus),
    .loaded(rootLoaded)
  );

  rpc_ctx_inval u_ctx_inval (
    .ref_clk(ref_clk),
    .rst(rst),
    .inv(inv),
    .ccReq(ccReq),
    .ccGran(ccGran),
    .ccDomain(ccDomain),
    .ccSource(ccSource),
    .ccFuncMask(ccFuncMask),
    .ccDone(ccDone),
    .ccActualGran(ccActualGran)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_root_staged;
    (wrRtaLo || wrRtaHi) && !setRootPointer && rootPointerStatus
      |=> $stable(activeRootBase) && $stable(activeMode);
  endproperty
  a_root_staged: assert property (p_root_staged) else $error("staged base took effect"); // RULE1

  property p_root_align;
    rtaReg[RTA_TTM_LSB-1:0] == '0 && activeRootBase[RTA_BASE_LSB-1:0] == '0;
  endproperty
  a_root_align: assert property (p_root_align) else $error("root base not page aligned"); // RULE2

  property p_haw_dropped;
    (rtaReg & ~RTA_MASK) == ZERO64;
  endproperty
  a_haw_dropped: assert property (p_haw_dropped) else $error("bits above width stored"); // RULE3

  property p_icc_start;
    iccRequest |=> iccBit && inv.busy;
  endproperty
  a_icc_start: assert property (p_icc_start) else $error("invalidate bit not set"); // RULE6

  property p_icc_finish;
    inv.done |=> !iccBit && actual_inval_granularity == $past(inv.actGran);
  endproperty
  a_icc_finish: assert property (p_icc_finish) else $error("completion not reported"); // RULE9

  sequence s_bad_request;
    iccRequest && stagedMode != MODE_LEGACY;
  endsequence

  property p_bad_mode;
    s_bad_request |=> ##1 !iccBit && actual_inval_granularity == GRAN_ERROR && !ccReq;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("non-legacy request not refused"); // RULE10

  property p_irq_level;
    ##1 irq == |(intSts & $past(intMask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt disagrees with status");

  // Legal starts hand the request to the cache in the very next cycle
  sequence s_legal_start;
    iccRequest && requestLegal;
  endsequence

  property p_req_issued;
    s_legal_start |=> ccReq && ccGran == $past(reqGran);
  endproperty
  a_req_issued: assert property (p_req_issued) else $error("request not issued"); // RULE7

  property p_req_fields;
    s_legal_start |=> ccDomain == $past(inv.domainIdentifier)
      && ccSource == $past(inv.sourceIdentifier);
  endproperty
  a_req_fields: assert property (p_req_fields) else $error("request fields lost"); // RULE11

  property p_no_req_bad;
    iccRequest && !requestLegal |=> !ccReq;
  endproperty
  a_no_req_bad: assert property (p_no_req_bad) else $error("bad request sent"); // RULE10

  sequence s_cache_ack;
    ccReq && ccDone;
  endsequence

  property p_ack_to_clear;
    s_cache_ack |=> inv.done ##1 !iccBit;
  endproperty
  a_ack_to_clear: assert property (p_ack_to_clear) else $error("ack not finished"); // RULE9

  // The invalidate bit may only fall through a completion
  property p_icc_hold;
    iccBit && !inv.done |=> iccBit;
  endproperty
  a_icc_hold: assert property (p_icc_hold) else $error("invalidate bit fell"); // RULE9

  property p_actual_inval_granularity_hold;
    !inv.done |=> $stable(actual_inval_granularity);
  endproperty
  a_actual_inval_granularity_hold: assert property (p_actual_inval_granularity_hold) else $error("granularity moved"); // RULE9

  // Dropped writes keep the pending request intact for the engine
  property p_busy_locked;
    iccBit && (wrCcmdLo || wrCcmdHi) |=> $stable(ccmdReg);
  endproperty
  a_busy_locked: assert property (p_busy_locked) else $error("busy write landed"); // RULE8

  property p_active_change;
    $changed(activeRootBase) || $changed(activeMode) |-> rootLoaded;
  endproperty
  a_active_change: assert property (p_active_change) else $error("active setup moved"); // RULE1

  property p_rta_held;
    !(wrRtaLo || wrRtaHi) |=> $stable(rtaReg);
  endproperty
  a_rta_held: assert property (p_rta_held) else $error("staged base moved"); // RULE1

  property p_rd_idle;
    !regRd |=> regRdData == ZERO32;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside window");

  property p_rd_cmd_zero;
    regRd && regAddr == OFF_GCMD |=> regRdData == ZERO32;
  endproperty
  a_rd_cmd_zero: assert property (p_rd_cmd_zero) else $error("command word readable");

  property p_rd_status;
    regRd && regAddr == OFF_GSTS |=> regRdData[GSTS_ROOT_POINTER_STATUS_BIT] == $past(rootPointerStatus);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong"); // RULE13

  property p_icc_readback;
    regRd && regAddr == OFF_CCMD_HI |=> regRdData[CCMD_ICC_BIT-DATA_W] == $past(iccBit);
  endproperty
  a_icc_readback: assert property (p_icc_readback) else $error("busy bit read wrong"); // RULE9

  property p_mask_write;
    wrIntMask |=> intMask == $past(intMaskMerged);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  // Each status bit is sticky until software writes a one, and an event always lands
  for (genvar i = 0; i < INT_W; i++) begin : g_int_chk
    property p_int_sticky;
      @(posedge ref_clk) disable iff (rst) intSts[i] && !intClear[i] |=> intSts[i];
    endproperty
    a_int_sticky: assert property (p_int_sticky) else $error("status bit lost");

    property p_int_set;
      @(posedge ref_clk) disable iff (rst) intEvents[i] |=> intSts[i];
    endproperty
    a_int_set: assert property (p_int_set) else $error("event not recorded");
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking testbench for the root pointer and context invalidation registers
`timescale 1ns/10ps
module tb_top;
  import rpc_pkg::*;
  localparam int LOAD = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [BE_W-1:0] regWrByteEn = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic irq;
  logic [63:0] activeRootBase;
  rpc_mode_type activeMode;
  logic dmaAbort;
  logic ccReq;
  rpc_gran_type ccGran;
  logic [15:0] ccDomain;
  logic [15:0] ccSource;
  logic [1:0] ccFuncMask;
  logic ccDone = 1'b0;
  rpc_gran_type ccActualGran = GRAN_ERROR;
  int num_errors = 0;
  int compares = 0;
  int seed = 14421;
  logic [31:0] expQ[$];
  logic rdPipe = 1'b0;
  logic [1:0] curCirg = 2'b00;
  logic [1:0] curCaig = 2'b00;

  always #2.5 ref_clk = ~ref_clk;

  rpc_regs_top #(.HOST_ADDR_WIDTH(48), .LOAD_CYC(LOAD)) rpc_regs_top_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrByteEn(regWrByteEn), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .irq(irq), .activeRootBase(activeRootBase), .activeMode(activeMode),
    .dmaAbort(dmaAbort), .ccReq(ccReq), .ccGran(ccGran), .ccDomain(ccDomain),
    .ccSource(ccSource), .ccFuncMask(ccFuncMask), .ccDone(ccDone),
    .ccActualGran(ccActualGran)
  );

  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so they are judged there
  always @(posedge ref_clk) begin
    if (rdPipe) begin
      if (expQ.size() == 0) begin
        num_errors++;
        $display("[FAIL] %0t read data with no expectation", $time);
      end else begin
        chk(regRdData, expQ.pop_front(), "read data");
      end
    end
    rdPipe <= regRd;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    regWrByteEn <= be;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask

  task automatic set_root_pointer_cmd();
    wr(OFF_GCMD, 32'h4000_0000, 4'hF);
    rd(OFF_GSTS, 32'h0000_0000);
    repeat (LOAD) @(posedge ref_clk);
    rd(OFF_GSTS, 32'h4000_0000);
  endtask

  task automatic inval(input logic [1:0] requested_inval_granularity, input logic [1:0] act, input logic [1:0] exp);
    logic [31:0] lo;
    logic [1:0] fm;
    logic ok;
    lo = $random(seed);
    fm = 2'($random(seed));
    ok = (exp != 2'b00);
    wr(OFF_CCMD_LO, lo, 4'hF);
    wr(OFF_CCMD_HI, {1'b1, requested_inval_granularity, 27'h0, fm}, 4'hF);
    // A refused request has already finished by the time this read lands
    rd(OFF_CCMD_HI, {ok, requested_inval_granularity, ok ? curCaig : 2'b00, 25'h0, fm});
    if (exp != 2'b00) begin
      // Software breaking the busy rule must not disturb the pending request
      wr(OFF_CCMD_LO, ~lo, 4'hF);
      chk(ccReq, 1'b1, "cache request");
      chk(ccGran, requested_inval_granularity, "requested granularity");
      chk({ccFuncMask, ccSource, ccDomain}, {fm, lo}, "request fields");
      @(posedge ref_clk);
      ccDone <= 1'b1;
      ccActualGran <= rpc_gran_type'(act);
      @(posedge ref_clk);
      ccDone <= 1'b0;
      ccActualGran <= rpc_gran_type'(~act);
    end
    repeat (3) @(posedge ref_clk);
    chk(ccReq, 1'b0, "request released");
    curCirg = requested_inval_granularity;
    curCaig = exp;
    rd(OFF_CCMD_HI, {1'b0, requested_inval_granularity, exp, 25'h0, fm});
    rd(OFF_CCMD_LO, lo);
  endtask

  initial begin
    logic [31:0] lo;
    logic [31:0] hi;
    logic [63:0] expBase;
    logic [1:0] md;
    expBase = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFF_RTA_LO, 32'h0000_0000);
    rd(OFF_RTA_HI, 32'h0000_0000);
    rd(OFF_CCMD_HI, 32'h0000_0000);
    rd(OFF_GSTS, 32'h0000_0000);
    rd(12'h040, 32'h0000_0000);
    hi = $random(seed);
    wr(OFF_RTA_HI, hi, 4'hF);
    rd(OFF_RTA_HI, hi & 32'h0000_FFFF);
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      lo = ($random(seed) & 32'hFFFF_F000) | (32'(md) << 10) | 32'h0000_03FF;
      // Translation is never enabled here, so any mode may be staged
      wr(OFF_RTA_LO, lo, 4'hF);
      rd(OFF_RTA_LO, lo & 32'hFFFF_FC00);
      chk(activeRootBase, expBase, "base held before command");
      set_root_pointer_cmd();
      expBase = {hi & 32'h0000_FFFF, lo & 32'hFFFF_F000};
      chk(activeRootBase, expBase, "active base");
      chk(activeMode, md, "active mode");
      chk(dmaAbort, md == 2'b11, "abort mode");
    end
    chk(irq, 1'b0, "masked interrupt");
    wr(OFF_INT_MASK, 32'h0000_0007, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1, "root loaded interrupt");
    wr(OFF_INT_STS, 32'h0000_0004, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0, "interrupt cleared");
    wr(OFF_RTA_LO, 32'h0000_0000, 4'hF);
    inval(2'b01, 2'b01, 2'b01);
    inval(2'b10, 2'b01, 2'b01);
    inval(2'b10, 2'b10, 2'b10);
    inval(2'b11, 2'b11, 2'b11);
    inval(2'b10, 2'b11, 2'b01);
    inval(2'b00, 2'b01, 2'b00);
    wr(OFF_CCMD_HI, 32'h8000_0000, 4'h7);
    repeat (2) @(posedge ref_clk);
    chk(ccReq, 1'b0, "no start without top byte");
    rd(OFF_CCMD_HI, {1'b0, curCirg, curCaig, 27'h0});
    for (int t = 1; t < 4; t++) begin
      wr(OFF_RTA_LO, 32'(t) << 10, 4'hF);
      inval(2'b01, 2'b01, 2'b00);
    end
    rd(OFF_INT_STS, 32'h0000_0003);
    chk(irq, 1'b1, "invalidation interrupt");
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
